// ### design/backup_supply_pkg.sv
/*
 Constants for the backup-domain supply control: register offset, field
 layout, level codes, reset values and the output mode encoding.
 Assumes a byte-wide register port supplied by the serial control port logic.
*/
// Behaviour
// - Decode codes 000-110 to levels, 111 reserved
// - Reset to 110 unless OTP default given
// - First coin insertion forces 1.0 V output
// - Leave first-insertion state once main input applied
// - Code 110: main regulator above, switch below
// - Codes 000-101: regulator from main or coin
// - Main input wins when above its threshold
// - Backup output can never be turned off
// - Level field bits 2:0 at address 0x6b
// - Level applies only with valid input present
`default_nettype none
package backup_supply_pkg;
	localparam logic [7:0] backup_supply_ctrl_addr = 8'h6b;
	localparam int level_lsb = 0;
	localparam int level_width = 3;
	localparam logic [2:0] level_reset = 3'h6;
	localparam logic [2:0] level_1v0 = 3'h0;
	localparam logic [2:0] level_3v0 = 3'h6;
	localparam logic [2:0] level_reserved = 3'h7;
	localparam logic [7:0] unused_mask = 8'hf8;

	typedef enum logic [1:0] {
		mode_main_regulator,
		mode_coin_regulator,
		mode_coin_switch
	} supply_mode_type;
endpackage : backup_supply_pkg
`default_nettype wire

// ### design/backup_supply_select_ctrl.sv
/*
 Control logic of the always-on backup supply: level register, source and
 mode selection from main input comparators, first-insertion handling.
 Assumes comparator and presence inputs arrive asynchronously from analog.
*/
`timescale 1ns/1ns
`default_nettype none
module backup_supply_select_ctrl
	import backup_supply_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// OTP default
	input wire logic otp_level_valid,
	input wire logic [2:0] otp_level,
	// Register port
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Analog status
	input wire logic main_high_rise,
	input wire logic main_high_fall,
	input wire logic main_low_rise,
	input wire logic main_low_fall,
	input wire logic coin_present,
	// Output control
	output logic [2:0] backup_level_sel,
	output logic [1:0] supply_mode,
	output logic backup_domain_output_en,
	output logic level_valid,
	output logic first_insertion
);
	// Synchroniser stages, one bit per analog status input
	logic [4:0] sync1_reg, sync2_reg;
	// Synchronised status, named by meaning
	logic high_rise_sync;
	logic high_fall_sync;
	logic low_rise_sync;
	logic low_fall_sync;
	logic coin_sync;
	// Level and supply state
	logic [2:0] level_reg;
	logic main_on_reg;
	logic first_reg;
	logic otp_load_reg;
	// Decoded views of the level code and the state
	logic reg_hit;
	logic level_is_switch_code;
	logic level_is_reserved;
	logic rise_seen;
	logic fall_seen;
	logic first_hold;
	logic [2:0] level_sel_next;
	logic level_valid_next;
	supply_mode_type mode_next;

	// Two-stage synchronisers for analog inputs
	always_ff @(posedge clock) begin
		if (srst) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= {coin_present, main_low_fall, main_low_rise, main_high_fall, main_high_rise};
			sync2_reg <= sync1_reg;
		end
	end

	assign high_rise_sync = sync2_reg[0];
	assign high_fall_sync = sync2_reg[1];
	assign low_rise_sync = sync2_reg[2];
	assign low_fall_sync = sync2_reg[3];
	assign coin_sync = sync2_reg[4];

	// Only one address is mapped on the register port
	assign reg_hit = reg_addr == backup_supply_ctrl_addr;

	// Code 110 alone may fall back to the pass switch
	assign level_is_switch_code = level_reg == level_3v0;
	assign level_is_reserved = level_reg == level_reserved;

	// Each level group watches its own comparator pair
	always_comb begin
		if (level_is_switch_code) begin
			rise_seen = high_rise_sync;
			fall_seen = high_fall_sync;
		end else begin
			rise_seen = low_rise_sync;
			fall_seen = low_fall_sync;
		end
	end

	// Hysteresis: rise sets, fall clears, rise wins when both
	always_ff @(posedge clock) begin
		if (srst) begin
			main_on_reg <= 1'b0;
		end else if (rise_seen) begin
			main_on_reg <= 1'b1;
		end else if (fall_seen) begin
			main_on_reg <= 1'b0;
		end
	end

	// One-shot strobe that lets the OTP default in after reset
	always_ff @(posedge clock) begin
		if (srst) begin
			otp_load_reg <= 1'b1;
		end else begin
			otp_load_reg <= 1'b0;
		end
	end

	// Level register; a write in the load cycle beats the OTP default
	always_ff @(posedge clock) begin
		if (srst) begin
			level_reg <= level_reset;
		end else if (reg_write && reg_hit) begin
			level_reg <= reg_wdata[level_lsb +: level_width];
		end else if (otp_load_reg && otp_level_valid) begin
			level_reg <= otp_level;
		end
	end

	// Read strobe echoed one cycle later
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
		end
	end

	// Read data: level in the low bits, unused bits and other addresses zero
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read && reg_hit) begin
			reg_rdata <= {5'h00, level_reg} & ~unused_mask;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// First insertion lasts until the main input is first seen
	always_ff @(posedge clock) begin
		if (srst) begin
			first_reg <= 1'b1;
		end else if (main_on_reg) begin
			first_reg <= 1'b0;
		end
	end

	// The 1.0 V hold ends in the same cycle as the main input is seen
	assign first_hold = first_reg && !main_on_reg;

	// Coin alone with code 110 stays a regulator until first main input
	always_comb begin
		if (main_on_reg) begin
			mode_next = mode_main_regulator;
		end else if (level_is_switch_code && !first_reg) begin
			mode_next = mode_coin_switch;
		end else begin
			mode_next = mode_coin_regulator;
		end
	end

	// Applied level: forced to 1.0 V during first insertion
	always_comb begin
		if (first_hold) begin
			level_sel_next = level_1v0;
		end else begin
			level_sel_next = level_reg;
		end
	end

	// A level only counts with a live source and a defined code
	assign level_valid_next = (main_on_reg || coin_sync) && !level_is_reserved;

	// Applied level output
	always_ff @(posedge clock) begin
		if (srst) begin
			backup_level_sel <= level_1v0;
		end else begin
			backup_level_sel <= level_sel_next;
		end
	end

	// Supply mode output
	always_ff @(posedge clock) begin
		if (srst) begin
			supply_mode <= 2'(mode_coin_regulator);
		end else begin
			supply_mode <= 2'(mode_next);
		end
	end

	// No path turns the output off
	always_ff @(posedge clock) begin
		if (srst) begin
			backup_domain_output_en <= 1'b1;
		end else begin
			backup_domain_output_en <= 1'b1;
		end
	end

	// Level validity output
	always_ff @(posedge clock) begin
		if (srst) begin
			level_valid <= 1'b0;
		end else begin
			level_valid <= level_valid_next;
		end
	end

	// First insertion flag output
	always_ff @(posedge clock) begin
		if (srst) begin
			first_insertion <= 1'b1;
		end else begin
			first_insertion <= first_hold;
		end
	end
endmodule : backup_supply_select_ctrl
`default_nettype wire

// ### tb/supply_checker.sv
/* Checker for the backup supply control ports.
 Assumes binding to the top module. */
`timescale 1ns/1ns
`default_nettype none
module supply_checker(
	input wire logic clock,
	input wire logic srst,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [2:0] backup_level_sel,
	input wire logic [1:0] supply_mode,
	input wire logic backup_domain_output_en,
	input wire logic level_valid,
	input wire logic first_insertion
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	property p_en; backup_domain_output_en; endproperty
	a_en: assert property (p_en) else $error("output off");
	property p_rv; reg_read |=> reg_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("no rvalid");
	property p_nv; !reg_read |=> !reg_rvalid; endproperty
	a_nv: assert property (p_nv) else $error("stray rvalid");
	property p_hi; reg_rvalid |-> reg_rdata[7:3] == 5'h00; endproperty
	a_hi: assert property (p_hi) else $error("high bits set");
	property p_na; reg_read && reg_addr != 8'h6b |=> reg_rdata == 8'h00; endproperty
	a_na: assert property (p_na) else $error("unmapped data");
	property p_fi; first_insertion |-> backup_level_sel == 3'h0; endproperty
	a_fi: assert property (p_fi) else $error("first level");
	property p_sw; supply_mode == 2'h2 |-> backup_level_sel == 3'h6; endproperty
	a_sw: assert property (p_sw) else $error("switch code");
	property p_mr; supply_mode == 2'h0 |-> !first_insertion; endproperty
	a_mr: assert property (p_mr) else $error("main in first");
	property p_lv; level_valid |-> backup_level_sel != 3'h7; endproperty
	a_lv: assert property (p_lv) else $error("reserved valid");
	property p_fm; first_insertion |-> supply_mode == 2'h1; endproperty
	a_fm: assert property (p_fm) else $error("first mode");
	property p_fs; !first_insertion |=> !first_insertion; endproperty
	a_fs: assert property (p_fs) else $error("first again");
endmodule : supply_checker
bind backup_supply_select_ctrl supply_checker chk_i(.clock(clock), .srst(srst), .reg_read(reg_read),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .backup_level_sel(backup_level_sel),
	.supply_mode(supply_mode), .backup_domain_output_en(backup_domain_output_en), .level_valid(level_valid),
	.first_insertion(first_insertion));
`default_nettype wire

// ### tb/backup_supply_select_ctrl_bench.sv
/* Bench for the backup supply control.
 Assumes the design package and the checker bind. */
`timescale 1ns/1ns
`default_nettype none
module backup_supply_select_ctrl_bench;
	logic clock = 0, srst = 1, ov = 0, wr = 0, rd = 0, c = 1, rv, en, lv, fi;
	logic [2:0] sel;
	logic [7:0] a = 8'h00, d = 8'h00, q;
	logic [3:0] m = 4'h0;
	logic [1:0] md;
	int err_total = 0, cmp_count = 0;
	always #10 clock = ~clock;
	backup_supply_select_ctrl DUT(.clock(clock), .srst(srst), .otp_level_valid(ov), .otp_level(3'h3),
		.reg_write(wr), .reg_read(rd), .reg_addr(a), .reg_wdata(d), .reg_rdata(q), .reg_rvalid(rv),
		.main_high_rise(m[3]), .main_high_fall(m[2]), .main_low_rise(m[1]), .main_low_fall(m[0]),
		.coin_present(c), .backup_level_sel(sel), .supply_mode(md), .backup_domain_output_en(en),
		.level_valid(lv), .first_insertion(fi));
	task chk(input string n, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task w(input logic [7:0] x, y);
		@(posedge clock) {wr, a, d} <= {1'b1, x, y};
		@(posedge clock) wr <= 1'b0;
	endtask : w
	task r(input logic [7:0] x, e);
		@(posedge clock) {rd, a} <= {1'b1, x};
		@(posedge clock) rd <= 1'b0;
		#1 chk("rdata", e, q);
		chk("rvalid", 8'h1, {7'h0, rv});
	endtask : r
	// Comparator inputs settle through the synchroniser
	task hold(input logic [3:0] x, input logic [7:0] e);
		@(posedge clock) m <= x;
		repeat (6) @(posedge clock);
		#1 chk("mode", e, {6'h0, md});
	endtask : hold
	task rst(input logic o);
		@(posedge clock) {srst, ov} <= {1'b1, o};
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		#1;
	endtask : rst
	task stop_test;
		$display("cmp %0d err %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	initial begin
		rst(1'b0);
		chk("sel", 8'h0, {5'h0, sel});
		chk("first", 8'h1, {7'h0, fi});
		r(8'h6b, 8'h06);
		for (int i = 0; i < 8; i++) begin
			w(8'h6b, 8'hf8 | i[7:0]);
			r(8'h6b, i[7:0]);
		end
		w(8'h6a, 8'h02);
		r(8'h6a, 8'h00);
		r(8'h6b, 8'h07);
		$display("regs done");
		w(8'h6b, 8'h05);
		hold(4'h2, 8'h0);
		chk("sel", 8'h5, {5'h0, sel});
		chk("first", 8'h0, {7'h0, fi});
		hold(4'h1, 8'h1);
		chk("sel", 8'h5, {5'h0, sel});
		w(8'h6b, 8'h06);
		hold(4'h8, 8'h0);
		hold(4'h4, 8'h2);
		chk("en", 8'h1, {7'h0, en});
		chk("valid", 8'h1, {7'h0, lv});
		$display("supply done");
		w(8'h6b, 8'h07);
		hold(4'h4, 8'h1);
		chk("sel", 8'h7, {5'h0, sel});
		chk("valid", 8'h0, {7'h0, lv});
		w(8'h6b, 8'h05);
		@(posedge clock) c <= 1'b0;
		hold(4'h1, 8'h1);
		chk("valid", 8'h0, {7'h0, lv});
		hold(4'h2, 8'h0);
		chk("valid", 8'h1, {7'h0, lv});
		@(posedge clock) c <= 1'b1;
		hold(4'h1, 8'h1);
		$display("levels done");
		rst(1'b1);
		r(8'h6b, 8'h03);
		hold(4'h1, 8'h1);
		chk("sel", 8'h0, {5'h0, sel});
		chk("first", 8'h1, {7'h0, fi});
		hold(4'h2, 8'h0);
		chk("sel", 8'h3, {5'h0, sel});
		chk("first", 8'h0, {7'h0, fi});
		$display("otp done");
		stop_test;
	end
endmodule : backup_supply_select_ctrl_bench
`default_nettype wire
